// ==== ems_pkg.sv ====
package ems_pkg;

    localparam logic [31:0] EMS_REG_CTRL    = 32'h0000_0000;
    localparam logic [31:0] EMS_REG_STATE   = 32'h0000_0004;
    localparam int          EMS_CTRL_BE     = 0;
    localparam int          EMS_CTRL_MP_HI  = 1;
    localparam logic [1:0]  EMS_CTRL_RESET  = 2'h0;
    localparam logic [1:0]  EMS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  EMS_RESP_SLVERR = 2'h2;

    localparam logic [1:0]  EMS_BW_8        = 2'h0;
    localparam logic [1:0]  EMS_BW_16       = 2'h1;
    localparam logic [1:0]  EMS_BW_32       = 2'h2;
    localparam logic [1:0]  EMS_BW_64       = 2'h3;
    localparam logic [3:0]  EMS_LANES       = 4'h8;

    localparam logic [5:0]  EMS_MP_BASE     = 6'h10;
    localparam logic [5:0]  EMS_MP_URGENT   = 6'h12;
    localparam logic [5:0]  EMS_XFER_BUSY   = 6'h14;
    localparam logic [5:0]  EMS_XFER_DONE   = 6'h15;
    localparam logic [5:0]  EMS_MP_ICACHE   = 6'h16;
    localparam logic [5:0]  EMS_MP_DEA      = 6'h18;
    localparam logic [5:0]  EMS_MP_DCACHE   = 6'h1a;
    localparam logic [5:0]  EMS_FRAME0      = 6'h1c;
    localparam logic [5:0]  EMS_FRAME1      = 6'h1d;
    localparam logic [5:0]  EMS_REFRESH     = 6'h1e;
    localparam logic [5:0]  EMS_IDLE        = 6'h1f;
    localparam logic [5:0]  EMS_DRAIN       = 6'h3f;

    typedef enum logic [3:0] {
        EMS_K_PP_PKT_LO, EMS_K_PP_PKT_HI, EMS_K_PP_ICACHE, EMS_K_PP_DEA,
        EMS_K_MP_PKT, EMS_K_MP_URGENT, EMS_K_XFER_BUSY, EMS_K_XFER_DONE,
        EMS_K_MP_ICACHE, EMS_K_MP_DEA, EMS_K_MP_DCACHE, EMS_K_FRAME0,
        EMS_K_FRAME1, EMS_K_REFRESH, EMS_K_IDLE, EMS_K_DRAIN
    } ems_kind_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  nbytes;
        logic        write;
        logic [63:0] wdata;
        ems_kind_e   kind;
        logic [1:0]  proc;
        logic [5:0]  row_code;
    } ems_req_s;

    function automatic logic [5:0] ems_col_code(input ems_kind_e k, input logic [1:0] p,
                                                input logic hi);
        logic [5:0] mp_hi;
        mp_hi = {5'h00, hi};
        unique case (k)
            EMS_K_PP_PKT_LO: ems_col_code = {2'h0, p, 2'h0};
            EMS_K_PP_PKT_HI: ems_col_code = {2'h0, p, 2'h1};
            EMS_K_PP_ICACHE: ems_col_code = {2'h0, p, 2'h2};
            EMS_K_PP_DEA:    ems_col_code = {2'h0, p, 2'h3};
            EMS_K_MP_PKT:    ems_col_code = EMS_MP_BASE | mp_hi;
            EMS_K_MP_URGENT: ems_col_code = EMS_MP_URGENT | mp_hi;
            EMS_K_XFER_BUSY: ems_col_code = EMS_XFER_BUSY;
            EMS_K_XFER_DONE: ems_col_code = EMS_XFER_DONE;
            EMS_K_MP_ICACHE: ems_col_code = EMS_MP_ICACHE | mp_hi;
            EMS_K_MP_DEA:    ems_col_code = EMS_MP_DEA | mp_hi;
            EMS_K_MP_DCACHE: ems_col_code = EMS_MP_DCACHE | mp_hi;
            EMS_K_FRAME0:    ems_col_code = EMS_FRAME0;
            EMS_K_FRAME1:    ems_col_code = EMS_FRAME1;
            EMS_K_REFRESH:   ems_col_code = EMS_REFRESH;
            EMS_K_IDLE:      ems_col_code = EMS_IDLE;
            EMS_K_DRAIN:     ems_col_code = EMS_DRAIN;
        endcase
    endfunction : ems_col_code

    function automatic logic [31:0] ems_col_shift(input logic [31:0] a, input logic [2:0] k);
        logic [31:0] r;
        int          sh;
        r  = a;
        sh = 7 + int'(k);
        if (k != 3'h0) begin
            r = 32'h0;
            r[2:0] = a[2:0];
            for (int p = 3; p < 32; p++) begin
                if (p >= sh) begin
                    r[p] = a[p - sh];
                end
            end
        end
        return r;
    endfunction : ems_col_shift

endpackage : ems_pkg

// ==== ems_ext_mem.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ems_ext_mem (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             req_valid,
    input  wire ems_pkg::ems_req_s req,
    output logic                  req_ready,
    output logic                  xfer_done,
    output logic [63:0]           xfer_rdata,
    input  wire logic [2:0]       column_shift_select,
    input  wire logic [1:0]       bus_width_select,
    output logic [31:0]           mem_addr,
    output logic [5:0]            mem_status,
    output logic                  row_latch_strobe_n,
    output logic [7:0]            byte_strobe_n,
    output logic [63:0]           mem_data_out,
    output logic                  mem_data_oe,
    input  wire logic [63:0]      mem_data_in
);
    import ems_pkg::*;

    typedef enum logic [1:0] {EMS_S_IDLE, EMS_S_ROW, EMS_S_COL} ems_state_e;

    ems_state_e  state;
    ems_state_e  next_state;
    ems_req_s    req_q;
    logic        be_q;
    logic [1:0]  bw_q;
    logic [2:0]  sh_q;
    logic [3:0]  end_q;
    logic [3:0]  disp_end;
    logic        last_q;
    logic [7:0]  col_cnt;
    logic [7:0]  last_cnt;
    logic [1:0]  ctrl;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [7:0]  rd_en;
    logic [2:0]  rd_lane [8];
    logic [7:0]  rd_buf  [8];

    wire         accept    = req_valid && req_ready;
    wire         in_row    = (state == EMS_S_ROW);
    wire         in_col    = (state == EMS_S_COL);
    wire [1:0]   bw        = in_row ? bus_width_select : bw_q;
    wire [2:0]   sh        = in_row ? column_shift_select : sh_q;
    wire [3:0]   pos       = in_row ? {1'b0, req_q.addr[2:0]} : disp_end;
    wire [3:0]   width     = 4'h1 << bw;
    wire [3:0]   base      = pos & ~(width - 4'h1);
    wire [3:0]   base_end  = base + width;
    wire [3:0]   cend      = (base_end < end_q) ? base_end : end_q;
    wire         last_col  = (cend >= end_q);
    wire [3:0]   lane_base = be_q ? (EMS_LANES - width) : 4'h0;
    wire [4:0]   req_end   = {2'h0, req.addr[2:0]} + {1'b0, req.nbytes};
    wire [31:0]  col_laddr = {req_q.addr[31:3], base[2:0]};
    wire [31:0]  col_paddr = ems_col_shift(col_laddr, sh);
    wire [5:0]   col_code  = ems_col_code(req_q.kind, req_q.proc, ctrl[EMS_CTRL_MP_HI]);
    wire         show_col  = in_row || (in_col && !last_q);
    wire [7:0]   lane_act;
    wire [63:0]  lane_data;
    wire [7:0]   byte_in;
    wire [2:0]   byte_lane [8];

    // Each lane carries the byte of the current chunk that falls on it.
    // The lane each read byte came from is kept one cycle, so the capture at the end
    // of a column uses the lanes that were on the pins, not those of the next column.
    for (genvar i = 0; i < 8; i++) begin : g_lane
        wire [3:0] li   = 4'(i);
        wire [3:0] lb   = base + li - lane_base;
        wire       in_w = (li >= lane_base) && (li < lane_base + width);
        assign lane_act[i]         = in_w && (lb >= pos) && (lb < cend);
        assign lane_data[8*i +: 8] = req_q.wdata[8*lb[2:0] +: 8];
        wire [3:0] bj   = 4'(i);
        assign byte_in[i]   = (bj >= pos) && (bj < cend);
        assign byte_lane[i] = 3'(lane_base + bj - base);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rd_buf[i] <= 8'h00;
            end else if (in_col && rd_en[i]) begin
                rd_buf[i] <= mem_data_in[8*rd_lane[i] +: 8];
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rd_lane[i] <= 3'h0;
            end else if (show_col) begin
                rd_lane[i] <= byte_lane[i];
            end
        end
        assign xfer_rdata[8*i +: 8] = rd_buf[i];
    end

    always_comb begin
        next_state = state;
        unique case (state)
            EMS_S_IDLE: if (accept) next_state = EMS_S_ROW;
            EMS_S_ROW:  next_state = EMS_S_COL;
            EMS_S_COL:  if (last_q) next_state = EMS_S_IDLE;
            default:    next_state = EMS_S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= EMS_S_IDLE;
            req_ready <= 1'b0;
            xfer_done <= 1'b0;
        end else begin
            state     <= next_state;
            req_ready <= (next_state == EMS_S_IDLE);
            xfer_done <= in_col && last_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= '0;
            be_q  <= 1'b0;
            end_q <= 4'h0;
        end else if (accept) begin
            req_q <= req;
            be_q  <= ctrl[EMS_CTRL_BE];
            end_q <= (req_end > 5'h08) ? 4'h8 : req_end[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bw_q <= EMS_BW_8;
            sh_q <= 3'h0;
        end else if (in_row) begin
            bw_q <= bus_width_select;
            sh_q <= column_shift_select;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_end <= 4'h0;
            last_q   <= 1'b0;
            rd_en    <= 8'h00;
            col_cnt  <= 8'h00;
            last_cnt <= 8'h00;
        end else if (show_col) begin
            disp_end <= cend;
            last_q   <= last_col;
            rd_en    <= req_q.write ? 8'h00 : byte_in;
            col_cnt  <= in_row ? 8'h01 : col_cnt + 8'h01;
        end else if (in_col) begin
            rd_en    <= 8'h00;
            last_cnt <= col_cnt;
        end
    end

    // Row time shows the full address and the requester's cycle type.
    // Column cycles show the shifted address, the requester code and the active strobes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr           <= 32'h0;
            mem_status         <= EMS_IDLE;
            row_latch_strobe_n <= 1'b1;
            byte_strobe_n      <= 8'hff;
            mem_data_out       <= 64'h0;
            mem_data_oe        <= 1'b0;
        end else if (accept) begin
            mem_addr           <= req.addr;
            mem_status         <= req.row_code;
            row_latch_strobe_n <= 1'b0;
            byte_strobe_n      <= 8'hff;
            mem_data_oe        <= 1'b0;
        end else if (show_col) begin
            mem_addr           <= col_paddr;
            mem_status         <= col_code;
            row_latch_strobe_n <= 1'b1;
            byte_strobe_n      <= ~lane_act;
            mem_data_out       <= lane_data;
            mem_data_oe        <= req_q.write;
        end else if (in_col) begin
            mem_status         <= EMS_IDLE;
            byte_strobe_n      <= 8'hff;
            mem_data_oe        <= 1'b0;
        end
    end

    // A write commits once address and data are both held and no response is pending.
    // A slow bready therefore holds back both write channels.
    wire         aw_fire = s_axi_awvalid && s_axi_awready;
    wire         w_fire  = s_axi_wvalid && s_axi_wready;
    wire         ar_fire = s_axi_arvalid && s_axi_arready;
    wire         wr_do   = aw_got && w_got && !s_axi_bvalid;
    wire         wr_ctrl = (awaddr_q == EMS_REG_CTRL);
    wire         next_aw = aw_fire || (aw_got && !wr_do);
    wire         next_w  = w_fire || (w_got && !wr_do);
    wire [31:0]  state_word = {16'h0, last_cnt, 2'h0, sh_q, bw_q, !req_ready};
    wire         rd_ok   = (s_axi_araddr == EMS_REG_CTRL) || (s_axi_araddr == EMS_REG_STATE);
    wire [31:0]  rd_word = (s_axi_araddr == EMS_REG_CTRL) ? {30'h0, ctrl} :
                           (s_axi_araddr == EMS_REG_STATE) ? state_word : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            awaddr_q      <= 32'h0;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_got        <= next_aw;
            w_got         <= next_w;
            s_axi_awready <= !next_aw;
            s_axi_wready  <= !next_w;
            if (aw_fire) awaddr_q <= {s_axi_awaddr[31:2], 2'h0};
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl         <= EMS_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= EMS_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ctrl ? EMS_RESP_OKAY : EMS_RESP_SLVERR;
            if (wr_ctrl && wstrb_q[0]) ctrl <= wdata_q[1:0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= EMS_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? EMS_RESP_OKAY : EMS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_taken;
        req_valid && req_ready;
    endsequence

    sequence s_row_then_col;
        in_row ##1 in_col;
    endsequence

    chk_row_full_addr: assert property (s_taken |=> mem_addr == $past(req.addr))
        else $error("row address not the full request address");
    chk_row_status_type: assert property (s_taken |=> mem_status == $past(req.row_code) && !row_latch_strobe_n)
        else $error("row status not the cycle type");
    chk_transfer_bound: assert property (s_taken |-> ##[3:10] xfer_done)
        else $error("transfer did not finish within the column limit");
    chk_pp_code: assert property (s_row_then_col ##0 (req_q.kind == EMS_K_PP_DEA) |-> mem_status == {2'h0, req_q.proc, 2'h3})
        else $error("parallel processor code wrong");
    chk_mp_pair: assert property (s_row_then_col ##0 (req_q.kind == EMS_K_MP_DCACHE) |-> mem_status == (EMS_MP_DCACHE | {5'h0, $past(ctrl[EMS_CTRL_MP_HI])}))
        else $error("master processor code or priority variant wrong");
    // Row time carries the requester's cycle type, where the top bit is legal.
    chk_no_reserved: assert property (row_latch_strobe_n && mem_status[5]
        |-> mem_status == EMS_DRAIN)
        else $error("reserved status code driven");
    chk_shift_low_bits: assert property (s_row_then_col |-> mem_addr[2:0] == $past(col_laddr[2:0]))
        else $error("column address low bits not kept");
    chk_lanes_32: assert property (in_col && bw_q == EMS_BW_32 && !be_q |-> byte_strobe_n[7:4] == 4'hf)
        else $error("32-bit little-endian strobe on upper half");
    chk_lanes_8: assert property (in_col && bw_q == EMS_BW_8 && be_q |-> byte_strobe_n[6:0] == 7'h7f)
        else $error("8-bit big-endian strobe off the top lane");
    chk_strobe_count: assert property (s_row_then_col ##0 (bw_q == EMS_BW_64) && (end_q == 4'h8) && (req_q.addr[2:0] == 3'h0) |-> byte_strobe_n == 8'h00)
        else $error("full doubleword on 64-bit bus not on all lanes");

    // Lane checks look at column cycles only; row and idle cycles keep every strobe high.
    chk_lanes_8_le: assert property (in_col && bw_q == EMS_BW_8 && !be_q
        |-> byte_strobe_n[7:1] == 7'h7f)
        else $error("8-bit little-endian strobe off the bottom lane");
    chk_lanes_16_le: assert property (in_col && bw_q == EMS_BW_16 && !be_q
        |-> byte_strobe_n[7:2] == 6'h3f)
        else $error("16-bit little-endian strobe off the bottom lanes");
    chk_lanes_16_be: assert property (in_col && bw_q == EMS_BW_16 && be_q
        |-> byte_strobe_n[5:0] == 6'h3f)
        else $error("16-bit big-endian strobe off the top lanes");
    chk_lanes_32_be: assert property (in_col && bw_q == EMS_BW_32 && be_q
        |-> byte_strobe_n[3:0] == 4'hf)
        else $error("32-bit big-endian strobe on lower half");
    chk_done_pulse: assert property (xfer_done
        |=> !xfer_done)
        else $error("transfer done held longer than one cycle");
    chk_row_no_strobe: assert property (!row_latch_strobe_n
        |-> byte_strobe_n == 8'hff && !mem_data_oe)
        else $error("byte strobe or data drive during row time");
    chk_shift_none: assert property (s_row_then_col ##0 (sh_q == 3'h0)
        |-> mem_addr == $past(col_laddr))
        else $error("unshifted column address differs from logical address");

endmodule : ems_ext_mem

// ==== ems_mem_model.sv ====
`timescale 1ns/1ps
module ems_mem_model (
    input  wire logic        aclk,
    input  wire logic [2:0]  cfg_shift,
    input  wire logic [1:0]  cfg_width,
    input  wire logic        row_latch_strobe_n,
    input  wire logic [7:0]  byte_strobe_n,
    output logic [2:0]       column_shift_select,
    output logic [1:0]       bus_width_select,
    output logic [63:0]      mem_data_in
);
    logic [7:0] junk = 8'h00;
    // Selects hold only during the row strobe; at other times they show the inverse.
    assign column_shift_select = row_latch_strobe_n ? ~cfg_shift : cfg_shift;
    assign bus_width_select    = row_latch_strobe_n ? ~cfg_width : cfg_width;
    always @(posedge aclk) begin
        junk <= junk + 8'h5b;
    end
    // Selected lanes return a lane-tagged byte; idle lanes carry a changing pattern.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            mem_data_in[8*i+:8] = byte_strobe_n[i] ? junk ^ 8'(i) : 8'h50 + 8'(i);
        end
    end
endmodule : ems_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import ems_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bus_width_select, cfg_width = '0;
    logic [31:0] s_axi_rdata, mem_addr;
    ems_req_s    req = '0;
    logic        req_ready, xfer_done, row_latch_strobe_n, mem_data_oe;
    logic [63:0] xfer_rdata, mem_data_out, mem_data_in;
    logic [2:0]  column_shift_select, cfg_shift = '0;
    logic [5:0]  mem_status;
    logic [7:0]  byte_strobe_n;
    logic [1:0]  rsp;
    logic [31:0] rd;
    int          n_fail = 0, compares = 0;

    ems_ext_mem ems_ext_mem_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req, .req_ready, .xfer_done,
        .xfer_rdata, .column_shift_select, .bus_width_select, .mem_addr, .mem_status,
        .row_latch_strobe_n, .byte_strobe_n, .mem_data_out, .mem_data_oe, .mem_data_in);
    ems_mem_model ems_mem_model_i (.aclk, .cfg_shift, .cfg_width, .row_latch_strobe_n,
        .byte_strobe_n, .column_shift_select, .bus_width_select, .mem_data_in);

    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic timed_out(input int t);
        if (t >= 40) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : timed_out

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int t;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (t = 0; t < 40; t++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        timed_out(t);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int t;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (t = 0; t < 40; t++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        timed_out(t);
    endtask : axi_read

    // One transfer; the expected columns, lanes and codes are built before it starts.
    task automatic run(input logic [31:0] a, input int n, input logic wr, input logic [63:0] wd,
                       input int k, input int p, input int bw, input int sh, input logic hi,
                       input logic be);
        int          w, b, last, col, t, ln, rows;
        logic [7:0]  es [8];
        logic [63:0] ed [8], em [8], erd;
        logic [5:0]  tbl [12];
        logic [5:0]  code;
        tbl = '{6'h10, 6'h12, 6'h14, 6'h15, 6'h16, 6'h18, 6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
                6'h3f};
        w = 1 << bw;
        last = int'(a[2:0]) + n - 1;
        last = last > 7 ? 7 : last;
        col = -1;
        erd = xfer_rdata;
        for (int i = 0; i < 8; i++) begin
            es[i] = 8'hff;
            ed[i] = '0;
            em[i] = '0;
        end
        for (b = int'(a[2:0]); b <= last; b++) begin
            if (col < 0 || b % w == 0) col++;
            ln = (be ? 8 - w : 0) + b % w;
            es[col][ln] = 1'h0;
            ed[col][8*ln+:8] = wd[8*b+:8];
            em[col][8*ln+:8] = 8'hff;
            erd[8*b+:8] = 8'h50 + 8'(ln);
        end
        code = k < 4 ? 6'(4 * p + k) : tbl[k-4] | 6'((k inside {4, 5, 8, 9, 10}) && hi);
        @(posedge aclk);
        req <= '{addr: a, nbytes: 4'(n), write: wr, wdata: wd, kind: ems_kind_e'(k),
                 proc: 2'(p), row_code: 6'h21};
        req_valid <= 1'h1;
        cfg_width <= 2'(bw);
        cfg_shift <= 3'(sh);
        for (t = 0; t < 40; t++) begin
            @(posedge aclk);
            if (req_ready === 1'h1) break;
        end
        req_valid <= 1'h0;
        timed_out(t);
        rows = 0;
        for (t = 0; t < 40; t++) begin
            #1;
            if (xfer_done === 1'h1) break;
            if (row_latch_strobe_n === 1'h0) begin
                rows++;
                check("row addr", mem_addr, a);
                check("row status", mem_status, 6'h21);
            end else if (byte_strobe_n !== 8'hff) begin
                check("col status", mem_status, code);
                check("strobes", byte_strobe_n, es[t-rows]);
                check("oe", mem_data_oe, wr);
                if (wr) check("lane data", mem_data_out & em[t-rows], ed[t-rows]);
                if (t == rows && a[2:0] == 3'h0)
                    check("col addr", mem_addr, sh == 0 ? a : 32'(a << (7 + sh)));
            end
            @(posedge aclk);
        end
        timed_out(t);
        check("row count", rows, 1);
        check("col count", t - rows, col + 1);
        check("ready at done", req_ready, 1'h1);
        if (!wr) check("read data", xfer_rdata, erd);
    endtask : run

    task automatic s_reset();
        repeat (3) @(posedge aclk);
        check("idle status", mem_status, 6'h1f);
        check("idle strobes", byte_strobe_n, 8'hff);
        check("idle row strobe", row_latch_strobe_n, 1'h1);
        check("busy in reset", req_ready, 1'h0);
        aresetn <= 1'h1;
    endtask : s_reset

    task automatic s_regs();
        axi_read(32'h0, rd, rsp);
        check("ctrl reset", rd, 32'h0);
        check("ctrl rresp", rsp, 2'h0);
        axi_read(32'h10, rd, rsp);
        check("unmapped rresp", rsp, 2'h2);
        check("unmapped rdata", rd, 32'h0);
        axi_write(32'h4, 32'h1, rsp);
        check("state bresp", rsp, 2'h2);
    endtask : s_regs

    task automatic s_widths();
        for (int i = 0; i < 8; i++) begin
            axi_write(32'h0, 32'(i % 2), rsp);
            run(32'h1357_9a00, 8, 1'h0, '0, 0, 1, i / 2, i, 1'h0, 1'(i % 2));
        end
    endtask : s_widths

    task automatic s_write();
        axi_write(32'h0, 32'h1, rsp);
        run(32'h0000_4403, 4, 1'h1, 64'h8877_6655_4433_2211, 3, 2, 1, 7, 1'h0, 1'h1);
        axi_read(32'h4, rd, rsp);
        check("state word", rd, 32'h0000_033a);
        check("state rresp", rsp, 2'h0);
        axi_write(32'h0, 32'h0, rsp);
        run(32'h0000_4405, 8, 1'h1, 64'h8877_6655_4433_2211, 1, 3, 2, 2, 1'h0, 1'h0);
    endtask : s_write

    task automatic s_kinds();
        for (int h = 0; h < 2; h++) begin
            axi_write(32'h0, 32'(2 * h), rsp);
            for (int k = 0; k < 16; k++) begin
                run(32'h0000_0800, 1, 1'h0, '0, k, k % 4, 3, 0, 1'(h), 1'h0);
            end
        end
    endtask : s_kinds

    initial begin
        s_reset();
        s_regs();
        s_widths();
        s_write();
        s_kinds();
        tally_and_finish();
    end
endmodule : tb_top
